// [include/scqs_params.svh]
// Timing and reset constants of the startup and clock-quality sequencer
`ifndef SCQS_PARAMS_SVH
`define SCQS_PARAMS_SVH

// ****************************************
// Clock rate
// ****************************************
`define SCQS_MCLK_MHZ        25

// ****************************************
// Timing figures in their own units
// ****************************************
`define SCQS_CQ_TIMEOUT_US   450000
`define SCQS_RST_PW_OSC      2
`define SCQS_STARTUP_OSC     192
`define SCQS_WAIT_RECOV_CYC  14
`define SCQS_MON_FAIL_KHZ    100
`define SCQS_QC_EDGES        4096

// ****************************************
// Derived cycle counts
// ****************************************
`define SCQS_CQ_TIMEOUT_CYC  (`SCQS_CQ_TIMEOUT_US * `SCQS_MCLK_MHZ)
`define SCQS_MON_FAIL_CYC    ((`SCQS_MCLK_MHZ * 1000) / `SCQS_MON_FAIL_KHZ)

// ****************************************
// Reset values
// ****************************************
`define SCQS_POR_FLAG_RST    1'b1
`define SCQS_OSC_TYPE_RST    1'b0

`endif

// [include/scqs_pkg.sv]
// Types of the startup and clock-quality sequencer
package scqs_pkg;

  // ****************************************
  // Sequencer states, one-hot
  // ****************************************
  typedef enum logic [6:0] {
    ST_QCHK    = 7'h01,
    ST_STARTUP = 7'h02,
    ST_RUN     = 7'h04,
    ST_STOP    = 7'h08,
    ST_LPWR    = 7'h10,
    ST_RECOV   = 7'h20,
    ST_EXTRST  = 7'h40
  } scqs_state_t;

endpackage : scqs_pkg

// [design/scqs_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none

module scqs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;

endmodule : scqs_sync

`default_nettype wire

// [design/scqs_top.sv]
// Startup and clock-quality sequencer top level
`timescale 1ns/1ns
`default_nettype none
`include "scqs_params.svh"


module scqs_top
  import scqs_pkg::*;
#(
  parameter int CQ_TIMEOUT_CYC = `SCQS_CQ_TIMEOUT_CYC,
  parameter int QC_EDGES       = `SCQS_QC_EDGES
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // Pins
  input  wire logic osc_clk,
  input  wire logic ext_reset_n,
  input  wire logic ext_irq,
  input  wire logic oscillator_type_select,
  // Processor side
  input  wire logic stop_req,
  input  wire logic pstop_req,
  input  wire logic wait_req,
  input  wire logic int_irq,
  input  wire logic power_on_flag_clr,
  // Status and control outputs
  output var  logic sys_reset_n,
  output var  logic clocks_released,
  output var  logic reset_vector_fetch,
  output var  logic irq_vector_fetch,
  output var  logic osc_enable,
  output var  logic self_clock_mode,
  output var  logic osc_full_swing,
  output var  logic clock_monitor_fail,
  output var  logic power_on_flag
);

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic rst_ff1_q;
  logic rst_n;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_ff1_q <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_ff1_q <= 1'b1;
      rst_n     <= rst_ff1_q;
    end
  end

  logic [3:0] pins_s;
  logic       osc_s;
  logic       ext_rst_n_s;
  logic       ext_irq_s;
  logic       type_s;

  scqs_sync #(.W(4)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   ({osc_clk, ext_reset_n, ext_irq, oscillator_type_select}),
    .dout  (pins_s)
  );

  assign osc_s       = pins_s[3];
  assign ext_rst_n_s = pins_s[2];
  assign ext_irq_s   = pins_s[1];
  assign type_s      = pins_s[0];

  // ****************************************
  // Constants at register width
  // ****************************************
  localparam logic [23:0] TO_LAST  = 24'(CQ_TIMEOUT_CYC - 1);
  localparam logic [12:0] QC_LAST  = 13'(QC_EDGES - 1);
  localparam logic [12:0] SU_LAST  = 13'(`SCQS_STARTUP_OSC - 1);
  localparam logic [12:0] WR_LAST  = 13'(`SCQS_WAIT_RECOV_CYC - 1);
  localparam logic [1:0]  RST_PW   = 2'(`SCQS_RST_PW_OSC);
  localparam logic [8:0]  MON_LIM  = 9'(`SCQS_MON_FAIL_CYC);

  // ****************************************
  // Sequencer
  // ****************************************
  scqs_state_t st_q, st_d;
  logic [12:0] cnt_q, cnt_d;
  logic [23:0] to_q, to_d;
  logic [8:0]  mon_q, mon_d;
  logic [1:0]  prw_q, prw_d;
  logic        osc_prev_q, osc_prev_d;
  logic        scm_q, scm_d;
  logic        ok_q, ok_d;
  logic        seq_q, seq_d;
  logic        rv_q, rv_d;
  logic        iv_q, iv_d;
  logic        oen_q, oen_d;
  logic        rel_q, rel_d;
  logic        srn_q, srn_d;
  logic        cmf_q, cmf_d;
  logic        pof_q, pof_d;
  logic        ots_q, ots_d;
  logic        osc_edge;
  logic        tick;
  logic        ext_hit;
  logic        mon_hit;
  logic        qc_pass;

  // Self clock ticks stand in for oscillator periods once the crystal is given up
  assign osc_edge = osc_s & ~osc_prev_q;
  assign tick     = scm_q | osc_edge;
  assign ext_hit  = ~ext_rst_n_s & (prw_q == RST_PW);
  assign mon_hit  = oen_q & ~scm_q & (st_q != ST_QCHK) & (mon_q >= MON_LIM);
  assign qc_pass  = (st_q == ST_QCHK) & osc_edge & (cnt_q == QC_LAST);

  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    to_d       = to_q;
    scm_d      = scm_q;
    ok_d       = ok_q;
    seq_d      = seq_q;
    rv_d       = 1'b0;
    iv_d       = 1'b0;
    osc_prev_d = osc_s;
    // Pulse width counted in oscillator periods, saturating
    if (!ext_rst_n_s) begin
      prw_d = (tick && prw_q != RST_PW) ? prw_q + 2'h1 : prw_q;
    end else begin
      prw_d = 2'h0;
    end
    // Monitor measures the gap between oscillator edges
    if (osc_edge || st_q == ST_QCHK || !oen_q) begin
      mon_d = 9'h000;
    end else begin
      mon_d = (mon_q == 9'h1ff) ? mon_q : mon_q + 9'h001;
    end
    if (ext_hit) begin
      st_d  = ST_EXTRST;
      seq_d = 1'b1;
      cnt_d = 13'h0000;
      to_d  = 24'h000000;
    end else begin
      case (st_q)
        ST_EXTRST: begin
          st_d = ok_q ? ST_STARTUP : ST_QCHK;
        end
        ST_QCHK: begin
          to_d = to_q + 24'h000001;
          if (osc_edge) begin
            cnt_d = cnt_q + 13'h0001;
          end
          if (qc_pass) begin
            ok_d  = 1'b1;
            scm_d = 1'b0;
          end else if (to_q == TO_LAST) begin
            scm_d = 1'b1;
          end
          if (qc_pass || to_q == TO_LAST) begin
            cnt_d = 13'h0000;
            st_d  = seq_q ? ST_STARTUP : ST_RUN;
            iv_d  = ~seq_q;
          end
        end
        ST_STARTUP: begin
          if (mon_hit) begin
            // A crystal that dies here would stall the tick count for good
            ok_d  = 1'b0;
            cnt_d = 13'h0000;
            to_d  = 24'h000000;
            st_d  = ST_QCHK;
          end else if (tick) begin
            cnt_d = cnt_q + 13'h0001;
            if (cnt_q == SU_LAST) begin
              st_d  = ST_RUN;
              seq_d = 1'b0;
              rv_d  = 1'b1;
            end
          end
        end
        ST_RUN: begin
          cnt_d = 13'h0000;
          to_d  = 24'h000000;
          if (mon_hit) begin
            ok_d = 1'b0;
            st_d = ST_QCHK;
          end else if (stop_req) begin
            ok_d = 1'b0;
            st_d = ST_STOP;
          end else if (pstop_req || wait_req) begin
            st_d = ST_LPWR;
          end
        end
        ST_STOP: begin
          if (ext_irq_s) begin
            st_d = ST_QCHK;
          end
        end
        ST_LPWR: begin
          if (ext_irq_s || int_irq) begin
            st_d = ST_RECOV;
          end
        end
        ST_RECOV: begin
          cnt_d = cnt_q + 13'h0001;
          if (cnt_q == WR_LAST) begin
            st_d = ST_RUN;
            iv_d = 1'b1;
          end
        end
        default: begin
          st_d = ST_QCHK;
        end
      endcase
    end
    oen_d = (st_d != ST_STOP);
    rel_d = (st_d == ST_RUN) | (st_d == ST_RECOV);
    srn_d = ~seq_d;
    // Failure stays up until the next passing check; a new hit wins
    cmf_d = mon_hit | (cmf_q & ~qc_pass);
    pof_d = pof_q & ~power_on_flag_clr;
    // Select is only taken while the internal reset is active
    ots_d = srn_q ? ots_q : type_s;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= ST_QCHK;
      cnt_q      <= 13'h0000;
      to_q       <= 24'h000000;
      mon_q      <= 9'h000;
      prw_q      <= 2'h0;
      osc_prev_q <= 1'b0;
      scm_q      <= 1'b0;
      ok_q       <= 1'b0;
      seq_q      <= 1'b1;
      rv_q       <= 1'b0;
      iv_q       <= 1'b0;
      oen_q      <= 1'b1;
      rel_q      <= 1'b0;
      srn_q      <= 1'b0;
      cmf_q      <= 1'b0;
      pof_q      <= `SCQS_POR_FLAG_RST;
      ots_q      <= `SCQS_OSC_TYPE_RST;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      to_q       <= to_d;
      mon_q      <= mon_d;
      prw_q      <= prw_d;
      osc_prev_q <= osc_prev_d;
      scm_q      <= scm_d;
      ok_q       <= ok_d;
      seq_q      <= seq_d;
      rv_q       <= rv_d;
      iv_q       <= iv_d;
      oen_q      <= oen_d;
      rel_q      <= rel_d;
      srn_q      <= srn_d;
      cmf_q      <= cmf_d;
      pof_q      <= pof_d;
      ots_q      <= ots_d;
    end
  end

  assign sys_reset_n        = srn_q;
  assign clocks_released    = rel_q;
  assign reset_vector_fetch = rv_q;
  assign irq_vector_fetch   = iv_q;
  assign osc_enable         = oen_q;
  assign self_clock_mode    = scm_q;
  assign osc_full_swing     = ots_q;
  assign clock_monitor_fail = cmf_q;
  assign power_on_flag      = pof_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_por_start_check: assert property ($rose(rst_n) |-> st_q == ST_QCHK && oen_q)
    else $error("check and oscillator not started at reset release");
  a_timeout_self_clk: assert property (st_q == ST_QCHK && to_q == TO_LAST
    && !qc_pass && !ext_hit |=> scm_q && st_q != ST_QCHK)
    else $error("time-out did not enter self clock");
  a_ext_rst_hit: assert property (ext_hit |=> !srn_q && st_q == ST_EXTRST)
    else $error("long external reset gave no internal reset");
  a_ext_rst_skip: assert property (st_q == ST_EXTRST && !ext_hit && ok_q |=> st_q == ST_STARTUP)
    else $error("external reset with oscillator ran a check");
  a_startup_end: assert property ($rose(rv_q) |-> $past(st_q) == ST_STARTUP && srn_q)
    else $error("reset vector fetch outside startup end");
  a_stop_wake_chk: assert property (st_q == ST_STOP && ext_irq_s && !ext_hit |=> st_q == ST_QCHK)
    else $error("stop wake skipped quality check");
  a_lpwr_osc_on: assert property (st_q == ST_LPWR || st_q == ST_RECOV |-> oen_q)
    else $error("oscillator stopped in pseudo-stop or wait");
  a_lpwr_wake: assert property (st_q == ST_LPWR && int_irq && !ext_hit |=> st_q == ST_RECOV)
    else $error("internal interrupt did not wake");
  a_recov_delay: assert property ($rose(st_q == ST_RECOV) && !ext_hit |-> ##14 iv_q || !srn_q)
    else $error("vector fetch not 14 cycles after wake");
  a_type_hold: assert property (srn_q && $past(srn_q) |-> $stable(ots_q))
    else $error("oscillator type changed outside reset");
  a_mon_fail: assert property (mon_hit
    && (st_q == ST_RUN || st_q == ST_STARTUP || ext_hit)
    |=> cmf_q && (st_q == ST_QCHK || st_q == ST_EXTRST))
    else $error("monitor failure not raised or not rechecked");
  a_por_flag_clr: assert property ($fell(pof_q) |-> $past(power_on_flag_clr))
    else $error("power-on flag fell without clear");

  c_self_clock: cover property (st_q == ST_QCHK ##1 scm_q);
  c_ext_reset: cover property (st_q == ST_EXTRST ##1 st_q == ST_STARTUP);
  c_wait_wake: cover property (st_q == ST_RECOV ##1 iv_q);
  c_stop_wake: cover property (st_q == ST_STOP ##1 st_q == ST_QCHK);

endmodule : scqs_top

`default_nettype wire

// [tb/scqs_osc_model.sv]
// Far-side model: crystal or square-wave source plus reset and interrupt pins
`timescale 1ns/1ns
`default_nettype none

module scqs_osc_model #(
  parameter int HALF_NS = 100
) (
  // Control from the bench
  input  wire logic osc_alive,
  input  wire logic rst_hold,
  input  wire logic irq_hold,
  // From the sequencer
  input  wire logic osc_enable,
  // Pins
  output var  logic osc_clk,
  output var  logic ext_reset_n,
  output var  logic ext_irq
);
  // ****************************************
  // Oscillator
  // ****************************************
  // A stopped or dead crystal stands low, so the monitor sees no edges
  initial begin
    osc_clk = 1'b0;
    forever begin
      #HALF_NS;
      if (osc_enable && osc_alive) begin
        osc_clk = ~osc_clk;
      end else begin
        osc_clk = 1'b0;
      end
    end
  end

  // ****************************************
  // Reset and interrupt pins
  // ****************************************
  assign ext_reset_n = ~rst_hold;
  assign ext_irq     = irq_hold;
endmodule : scqs_osc_model

`default_nettype wire

// [tb/scqs_top_tb.sv]
// Self-checking bench of the startup and clock-quality sequencer
`timescale 1ns/1ns
`default_nettype none

module scqs_top_tb;
  // ****************************************
  // Signals
  // ****************************************
  localparam int TMO = 200;
  localparam int QCE = 8;
  logic mclk, arst_n, osc_clk, ext_reset_n, ext_irq, oscillator_type_select;
  logic stop_req, pstop_req, wait_req, int_irq, power_on_flag_clr;
  logic sys_reset_n, clocks_released, reset_vector_fetch, irq_vector_fetch;
  logic osc_enable, self_clock_mode, osc_full_swing, clock_monitor_fail, power_on_flag;
  logic osc_alive, rst_hold, irq_hold;
  int   err_count, samples_checked, cyc, osc_edges, n, e0, k;

  // Short counts keep the run brief
  scqs_top #(.CQ_TIMEOUT_CYC(TMO), .QC_EDGES(QCE)) dut (.*);
  scqs_osc_model u_far (.osc_alive(osc_alive), .rst_hold(rst_hold), .irq_hold(irq_hold),
    .osc_enable(osc_enable), .osc_clk(osc_clk), .ext_reset_n(ext_reset_n), .ext_irq(ext_irq));

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;
  always @(posedge osc_clk) osc_edges++;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up;
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic pick(input int w);
    case (w)
      0: return reset_vector_fetch;
      1: return irq_vector_fetch;
      2: return osc_enable;
      3: return clock_monitor_fail;
      default: return self_clock_mode;
    endcase
  endfunction : pick

  // Bounded wait; a miss counts as a mismatch
  task automatic wait_for(input int w, input int lim);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (pick(w) !== 1'b1 && n < lim);
    if (pick(w) !== 1'b1) check(16'h0, 16'h1);
    @(negedge mclk);
  endtask : wait_for

  task automatic power_on;
    arst_n = 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    e0 = osc_edges;
  endtask : power_on

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {stop_req, pstop_req, wait_req, int_irq, power_on_flag_clr} = 5'h00;
    {rst_hold, irq_hold, arst_n} = 3'h0;
    osc_alive = 1'b1;
    oscillator_type_select = 1'b1;
    power_on();
    check(osc_enable, 1'h1);
    wait_for(0, 3000);
    check((osc_edges - e0) >= 200 && (osc_edges - e0) <= 212, 1'h1);
    check(self_clock_mode, 1'h0);
    check(power_on_flag, 1'h1);
    oscillator_type_select = 1'b0;
    repeat (6) @(negedge mclk);
    check(osc_full_swing, 1'h1);
    check({sys_reset_n, clocks_released}, 2'h3);
    power_on_flag_clr = 1'b1;
    @(negedge mclk) power_on_flag_clr = 1'b0;
    @(negedge mclk) check(power_on_flag, 1'h0);
    // Wait and pseudo-stop, woken by internal then external interrupt
    for (k = 0; k < 4; k++) begin
      if (k[0]) pstop_req = 1'b1;
      else wait_req = 1'b1;
      @(negedge mclk) {pstop_req, wait_req} = 2'h0;
      repeat (3) @(negedge mclk);
      check({clocks_released, osc_enable}, 2'h1);
      if (k[1]) irq_hold = 1'b1;
      else int_irq = 1'b1;
      wait_for(1, 40);
      check(n >= 14 && n <= (k[1] ? 19 : 16), 1'h1);
      {irq_hold, int_irq} = 2'h0;
      repeat (4) @(negedge mclk);
    end
    // Full stop: internal interrupt refused, external wakes via quality check
    stop_req = 1'b1;
    @(negedge mclk) stop_req = 1'b0;
    repeat (3) @(negedge mclk);
    check({osc_enable, clocks_released}, 2'h0);
    int_irq = 1'b1;
    repeat (20) @(negedge mclk);
    int_irq = 1'b0;
    check({osc_enable, clocks_released}, 2'h0);
    irq_hold = 1'b1;
    e0 = osc_edges;
    wait_for(1, 2000);
    irq_hold = 1'b0;
    check((osc_edges - e0) >= QCE, 1'h1);
    check(sys_reset_n, 1'h1);
    // External reset shorter than two oscillator periods is ignored
    rst_hold = 1'b1;
    repeat (2) @(negedge mclk);
    rst_hold = 1'b0;
    repeat (10) @(negedge mclk);
    check(sys_reset_n, 1'h1);
    rst_hold = 1'b1;
    repeat (40) @(negedge mclk);
    check(sys_reset_n, 1'h0);
    rst_hold = 1'b0;
    e0 = osc_edges;
    wait_for(0, 2000);
    check((osc_edges - e0) >= 192 && (osc_edges - e0) <= 200, 1'h1);
    check(osc_full_swing, 1'h0);
    check(power_on_flag, 1'h0);
    // Dead oscillator: monitor, time-out, self clock
    osc_alive = 1'b0;
    wait_for(3, 400);
    check(n >= 240 && n <= 262, 1'h1);
    wait_for(4, 400);
    check(n >= TMO - 2 && n <= TMO + 6, 1'h1);
    check(irq_vector_fetch, 1'h1);
    check(clocks_released, 1'h1);
    // Power-on with no oscillation: self clock then startup on mclk ticks
    power_on();
    wait_for(4, 400);
    check(n >= TMO && n <= TMO + 6, 1'h1);
    wait_for(0, 400);
    check(n >= 192 && n <= 198, 1'h1);
    check(power_on_flag, 1'h1);
    osc_alive = 1'b1;
    repeat (4) @(negedge mclk);
    wrap_up();
  end

  initial begin
    {err_count, samples_checked, cyc, osc_edges} = '0;
  end
endmodule : scqs_top_tb

`default_nettype wire
